// ---- core/jtsm_mapper.sv ----
// Sample-to-lane mapper with two-entry output buffer
`timescale 1ns/10ps
`include "jtsm_defines.svh"

module jtsm_mapper (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Mode control
  input wire logic [`JTSM_MODE_W-1:0] link_mode_select,
  output logic mode_err,
  output logic [`JTSM_NUM_LANES-1:0] lane_pwr_en,
  // Sample frames in
  input wire logic in_valid,
  output logic in_ready,
  input wire jtsm_pkg::jtsm_in_t in_data,
  // Lane frames out
  output logic out_valid,
  input wire logic out_ready,
  output jtsm_pkg::jtsm_out_t out_data
);

  ////////////////////////////////////////////////////////////////////////
  // Mode tables

  function automatic logic mode_ok(input logic [`JTSM_MODE_W-1:0] m);
    mode_ok = (m >= `JTSM_MODE_1) && (m <= `JTSM_MODE_11); // [RL18]
  endfunction

  function automatic logic [3:0] lane_cnt(input logic [`JTSM_MODE_W-1:0] m);
    unique case (m)
      `JTSM_MODE_1, `JTSM_MODE_6: lane_cnt = `JTSM_LANES_6;
      `JTSM_MODE_2, `JTSM_MODE_3, `JTSM_MODE_7, `JTSM_MODE_8: lane_cnt = `JTSM_LANES_4;
      `JTSM_MODE_4: lane_cnt = `JTSM_LANES_3;
      `JTSM_MODE_5: lane_cnt = `JTSM_LANES_2;
      `JTSM_MODE_9, `JTSM_MODE_10, `JTSM_MODE_11: lane_cnt = `JTSM_LANES_8;
      default: lane_cnt = 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] oct_cnt(input logic [`JTSM_MODE_W-1:0] m);
    unique case (m)
      `JTSM_MODE_1, `JTSM_MODE_4, `JTSM_MODE_5, `JTSM_MODE_6: oct_cnt = `JTSM_OCT_2;
      `JTSM_MODE_2, `JTSM_MODE_7, `JTSM_MODE_9: oct_cnt = `JTSM_OCT_1;
      `JTSM_MODE_3, `JTSM_MODE_10: oct_cnt = `JTSM_OCT_5;
      `JTSM_MODE_8: oct_cnt = `JTSM_OCT_3;
      `JTSM_MODE_11: oct_cnt = `JTSM_OCT_8;
      default: oct_cnt = 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Placement of one lane; frames are left-justified, MSB sent first

  function automatic logic [`JTSM_LANE_W-1:0] map_lane(
    input logic [`JTSM_MODE_W-1:0] m,
    input int l,
    input jtsm_pkg::jtsm_in_t d
  );
    logic [`JTSM_LANE_W-1:0] w;
    int c;
    int k;
    // Unused positions and tail stay zero [RL14]
    w = '0;
    c = 0;
    k = 0;
    unique case (m)
      `JTSM_MODE_1, `JTSM_MODE_6: begin // [RL3]
        if (l < 6) begin
          c = 2 * (l / 3);
          k = l % 3;
          if (k == 0) begin
            w[63:48] = {d.smp[c][0], d.smp[c][1][11:8]}; // [RL1]
          end else if (k == 1) begin
            w[63:48] = {d.smp[c][1][7:0], d.smp[c+1][0][11:4]}; // [RL1]
          end else begin
            w[63:48] = {d.smp[c+1][0][3:0], d.smp[c+1][1]}; // [RL2]
          end
        end
      end
      `JTSM_MODE_2, `JTSM_MODE_7: begin
        if (l < 4) begin
          w[63:56] = d.smp[l][0][7:0]; // [RL4] [RL8]
        end
      end
      `JTSM_MODE_3: begin
        if (l < 4) begin
          w[63:24] = {d.smp[l][0][9:0], d.smp[l][1][9:0],
                      d.smp[l][2][9:0], d.smp[l][3][9:0]}; // [RL5]
        end
      end
      `JTSM_MODE_4: begin
        if (l == 0) begin
          w[63:48] = {d.smp[0][0], d.smp[1][0][11:8]}; // [RL6]
        end else if (l == 1) begin
          w[63:48] = {d.smp[1][0][7:0], d.smp[2][0][11:4]}; // [RL6]
        end else if (l == 2) begin
          w[63:48] = {d.smp[2][0][3:0], d.smp[3][0]}; // [RL6]
        end
      end
      `JTSM_MODE_5: begin
        if (l < 2) begin
          w[63:48] = {d.smp[2*l][0][7:0], d.smp[2*l+1][0][7:0]}; // [RL7]
        end
      end
      `JTSM_MODE_8: begin
        if (l < 4) begin
          w[63:40] = {d.smp[l][0], d.smp[l][1]}; // [RL9]
        end
      end
      `JTSM_MODE_9: begin
        w[63:56] = d.smp[l/2][l%2][7:0]; // [RL10]
      end
      `JTSM_MODE_10: begin
        c = l / 2;
        k = l % 2;
        w[63:24] = {d.smp[c][k][9:0], d.smp[c][k+2][9:0],
                    d.smp[c][k+4][9:0], d.smp[c][k+6][9:0]}; // [RL11]
      end
      `JTSM_MODE_11: begin
        // Channels C and D are not carried in this mode [RL12]
        c = l / 4;
        k = l % 4;
        w[63:4] = {d.smp[c][k], d.smp[c][k+4], d.smp[c][k+8],
                   d.smp[c][k+12], d.smp[c][k+16]}; // [RL13]
      end
      default: w = '0; // [RL18]
    endcase
    map_lane = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Mapping and lane enables

  jtsm_pkg::jtsm_out_t mapped;

  for (genvar gl = 0; gl < `JTSM_NUM_LANES; gl++) begin : g_lane
    always_comb begin
      mapped.lane[gl] = map_lane(link_mode_select, gl, in_data);
      mapped.lane_en[gl] = (4'(gl) < lane_cnt(link_mode_select)); // [RL15]
    end
  end

  always_comb begin
    mapped.octets = oct_cnt(link_mode_select);
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode status; upper lanes powered down, bad modes keep last good set

  logic [`JTSM_NUM_LANES-1:0] pwr_en_q, pwr_en_d;
  logic mode_err_q, mode_err_d;

  always_comb begin
    mode_err_d = !mode_ok(link_mode_select); // [RL18]
    pwr_en_d = pwr_en_q;
    if (mode_ok(link_mode_select)) begin
      pwr_en_d = mapped.lane_en; // [RL15]
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_en_q <= '0;
      mode_err_q <= 1'b0;
    end else begin
      pwr_en_q <= pwr_en_d;
      mode_err_q <= mode_err_d;
    end
  end

  assign lane_pwr_en = pwr_en_q;
  assign mode_err = mode_err_q;

  ////////////////////////////////////////////////////////////////////////
  // Two-entry buffer; a receiver stall backs up to in_ready, no loss

  jtsm_pkg::jtsm_out_t [`JTSM_BUF_DEPTH-1:0] mem_q, mem_d;
  logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'(`JTSM_BUF_DEPTH));
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];

  always_comb begin
    // Frames under an undefined mode are taken and dropped [RL18]
    push = in_valid && in_ready && mode_ok(link_mode_select);
    pop = out_valid && out_ready;
    mem_d = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_ptr_q] = mapped;
      wr_ptr_d = !wr_ptr_q;
    end
    if (pop) begin
      rd_ptr_d = !rd_ptr_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_q <= '0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// ---- shared/jtsm_defines.svh ----
// Constants of the transport-layer sample mapper
// Functional notes
// RL1 - Mode 1: two samples per channel, six lanes
// RL2 - Mode 1: lane 2 split, lanes 3-5 repeat
// RL3 - Mode 6 uses mode 1 placement
// RL4 - Mode 2: one octet, channel per lane
// RL5 - Mode 3: four 10-bit samples per lane
// RL6 - Mode 4: one sample per channel, three lanes
// RL7 - Mode 5: two channels per two-octet lane
// RL8 - Mode 7: one octet, channel per lane
// RL9 - Mode 8: two 12-bit samples per lane
// RL10 - Mode 9: even/odd lane pair per channel
// RL11 - Mode 10: even/odd sample lanes, 10-bit
// RL12 - Mode 11: two channels, four lanes each
// RL13 - Mode 11: lane k samples k+4n, tail nibble
// RL14 - Tail bits zero, samples MSB first
// RL15 - Lowest lanes used, upper lanes powered down
// RL16 - Receiver connects to lowest indexed lanes
// RL17 - Receiver inverts placement to rebuild streams
// RL18 - Undefined link modes rejected, nothing emitted
`ifndef JTSM_DEFINES_SVH
`define JTSM_DEFINES_SVH

`define JTSM_NUM_CH 4
`define JTSM_NUM_SMP 20
`define JTSM_SMP_W 12
`define JTSM_NUM_LANES 8
`define JTSM_LANE_W 64
`define JTSM_MODE_W 4
`define JTSM_BUF_DEPTH 2
`define JTSM_TAIL_W 4

`define JTSM_MODE_1 4'h1
`define JTSM_MODE_2 4'h2
`define JTSM_MODE_3 4'h3
`define JTSM_MODE_4 4'h4
`define JTSM_MODE_5 4'h5
`define JTSM_MODE_6 4'h6
`define JTSM_MODE_7 4'h7
`define JTSM_MODE_8 4'h8
`define JTSM_MODE_9 4'h9
`define JTSM_MODE_10 4'ha
`define JTSM_MODE_11 4'hb

`define JTSM_LANES_2 4'h2
`define JTSM_LANES_3 4'h3
`define JTSM_LANES_4 4'h4
`define JTSM_LANES_6 4'h6
`define JTSM_LANES_8 4'h8

`define JTSM_OCT_1 4'h1
`define JTSM_OCT_2 4'h2
`define JTSM_OCT_3 4'h3
`define JTSM_OCT_5 4'h5
`define JTSM_OCT_8 4'h8

`endif

// ---- shared/jtsm_pkg.sv ----
// Types of the transport-layer sample mapper
`include "jtsm_defines.svh"

package jtsm_pkg;

  typedef logic [`JTSM_SMP_W-1:0] jtsm_smp_t;

  typedef struct packed {
    logic [`JTSM_NUM_CH-1:0][`JTSM_NUM_SMP-1:0][`JTSM_SMP_W-1:0] smp;
  } jtsm_in_t;

  typedef struct packed {
    logic [`JTSM_NUM_LANES-1:0][`JTSM_LANE_W-1:0] lane;
    logic [`JTSM_NUM_LANES-1:0] lane_en;
    logic [3:0] octets;
  } jtsm_out_t;

endpackage

// ---- sim/jtsm_mapper_props.sv ----
// Assertion checker for the lane mapper
`timescale 1ns/10ps
module jtsm_mapper_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Watched ports
  input wire logic [3:0] link_mode_select,
  input wire logic mode_err,
  input wire logic [7:0] lane_pwr_en,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire jtsm_pkg::jtsm_out_t out_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire ok = link_mode_select inside {[4'h1:4'hb]};
  sequence take_s; in_valid && in_ready; endsequence
  sequence idle_s; !out_valid; endsequence
  a_bad_flag: assert property (!ok |=> mode_err) else $error("no mode flag");
  a_good_clear: assert property (ok |=> !mode_err) else $error("mode flag stuck");
  a_bad_drop: assert property (take_s ##0 idle_s ##0 !ok |=> !out_valid)
    else $error("bad mode emitted");
  a_good_emit: assert property (take_s ##0 idle_s ##0 ok |=>
    out_valid && out_data.lane_en == lane_pwr_en) else $error("frame lost");
  a_pwr_nine: assert property (link_mode_select == 4'h9 |=> lane_pwr_en == 8'hff)
    else $error("mode 9 lanes");
  a_pwr_four: assert property (link_mode_select == 4'h4 |=> lane_pwr_en == 8'h07)
    else $error("mode 4 lanes");
  a_pwr_hold: assert property (!ok |=> $stable(lane_pwr_en)) else $error("lanes moved");
  a_tail_zero: assert property (out_valid && out_data.octets == 4'h8 |->
    out_data.lane[0][3:0] == 4'h0 && out_data.lane[7][3:0] == 4'h0) else $error("tail");
  a_lane_low: assert property (out_valid |->
    ((out_data.lane_en + 8'h1) & out_data.lane_en) == 8'h0) else $error("lanes not lowest");
endmodule
bind jtsm_mapper jtsm_mapper_props i_props (.ref_clk, .resetn, .link_mode_select, .mode_err,
  .lane_pwr_en, .in_valid, .in_ready, .out_valid, .out_data);

// ---- sim/jtsm_mapper_test.sv ----
// Self-checking bench for the lane mapper
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module jtsm_mapper_test;
  typedef struct {logic [3:0] m; int w, g, k; logic [3:0] oct; logic [7:0] en;} jtsm_row_t;
  logic ref_clk = 0, resetn = 0, in_valid = 0, stall = 0;
  // Starts on a defined mode so the first edge after reset raises no flag
  logic [3:0] link_mode_select = 4'h1;
  logic mode_err, in_ready, out_valid, out_ready;
  logic [7:0] lane_pwr_en;
  jtsm_pkg::jtsm_in_t in_data;
  jtsm_pkg::jtsm_out_t out_data;
  int fail_count = 0, tests_run = 0;
  logic [3:0] bad[3] = '{4'h0, 4'hc, 4'hf};
  // Zero g marks modes whose samples run on across lane borders
  jtsm_row_t rows[11] = '{'{4'h1,12,0,2,4'h2,8'h3f}, '{4'h2,8,1,1,4'h1,8'h0f},
    '{4'h3,10,1,4,4'h5,8'h0f}, '{4'h4,12,0,1,4'h2,8'h07}, '{4'h5,8,0,1,4'h2,8'h03},
    '{4'h6,12,0,2,4'h2,8'h3f}, '{4'h7,8,1,1,4'h1,8'h0f}, '{4'h8,12,1,2,4'h3,8'h0f},
    '{4'h9,8,2,1,4'h1,8'hff}, '{4'ha,10,2,4,4'h5,8'hff}, '{4'hb,12,4,5,4'h8,8'hff}};
  jtsm_mapper i_dut (.ref_clk, .resetn, .link_mode_select, .mode_err, .lane_pwr_en,
    .in_valid, .in_ready, .in_data, .out_valid, .out_ready, .out_data);
  jtsm_rx_model i_rx (.ref_clk, .resetn, .stall, .out_valid, .out_ready, .out_data);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] sv(int c, int n);
    // Channel shows in the low byte too, so 8-bit lanes tell channels apart
    return 12'h801 + 12'(c * 64 + n * 3);
  endfunction
  function automatic jtsm_pkg::jtsm_out_t exp_of(jtsm_row_t r);
    jtsm_pkg::jtsm_out_t x;
    logic [11:0] v;
    int lb, l, i, c, n, p, q;
    x = '0;
    x.lane_en = r.en;
    x.octets = r.oct;
    lb = r.oct * 8;
    for (int j = 0; j < 80; j++) begin
      l = j / r.k;
      i = j % r.k;
      c = r.g ? l / r.g : l;
      n = r.g ? l % r.g + r.g * i : i;
      p = r.g ? l * lb + i * r.w : j * r.w;
      v = sv(c, n);
      if (l < 8 && (r.g ? r.en[l] : l < 4)) begin
        for (int b = 0; b < r.w; b++) begin
          q = p + r.w - 1 - b;
          x.lane[q / lb][63 - q % lb] = v[b];
        end
      end
    end
    return x;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic send(logic [3:0] m);
    int n;
    n = 0;
    link_mode_select <= m;
    in_valid <= 1'b1;
    // Ready is judged mid-cycle, as the next rising edge will see it
    @(negedge ref_clk);
    while (!in_ready && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
  endtask
  task automatic take(jtsm_pkg::jtsm_out_t e);
    jtsm_pkg::jtsm_out_t g;
    repeat (20) if (i_rx.q.size() == 0) @(posedge ref_clk);
    g = i_rx.q.size() ? i_rx.q.pop_front() : '0;
    `CHK("frame", e, g)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    foreach (in_data.smp[c, n]) in_data.smp[c][n] <= sv(c, n);
    repeat (12) @(posedge ref_clk);
    `CHK("reset lanes", 8'h00, lane_pwr_en)
    `CHK("reset flag", 1'b0, mode_err)
    resetn <= 1'b1;
    foreach (rows[r]) begin
      send(rows[r].m);
      in_valid <= 1'b0;
      take(exp_of(rows[r]));
      `CHK("lane_pwr_en", rows[r].en, lane_pwr_en)
    end
    // Receiver stalls; the third frame must wait, not vanish
    stall <= 1'b1;
    send(4'hb);
    send(4'ha);
    link_mode_select <= 4'h3;
    repeat (3) @(posedge ref_clk);
    `CHK("in_ready", 1'b0, in_ready)
    stall <= 1'b0;
    send(4'h3);
    in_valid <= 1'b0;
    take(exp_of(rows[10]));
    take(exp_of(rows[9]));
    take(exp_of(rows[2]));
    foreach (bad[i]) begin
      send(bad[i]);
      in_valid <= 1'b0;
      @(posedge ref_clk);
      `CHK("mode_err", 1'b1, mode_err)
      `CHK("held lanes", 8'h0f, lane_pwr_en)
      repeat (2) @(posedge ref_clk);
      `CHK("dropped", 1'b0, out_valid)
    end
    resetn <= 1'b0;
    @(posedge ref_clk);
    `CHK("second reset", 8'h00, lane_pwr_en)
    wrap_up();
  end
endmodule

// ---- sim/jtsm_rx_model.sv ----
// Receiver model that takes lane frames and can stall
`timescale 1ns/10ps
module jtsm_rx_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bench control
  input wire logic stall,
  // Lane frames
  input wire logic out_valid,
  output logic out_ready,
  input wire jtsm_pkg::jtsm_out_t out_data
);
  jtsm_pkg::jtsm_out_t q[$];
  // Ready changes only after an edge, so no frame is half taken
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !stall;
      if (out_valid && out_ready) begin
        q.push_back(out_data);
      end
    end
  end
endmodule
